// ### src/adc_conversion_sequencer.sv
// Conversion sequencer of a successive-approximation converter.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Contract
// - Resolution bit keeps 10 or upper 8 bits.
// - Free running waits for software start.
// - Free running restarts after each completion.
// - Enable bit gates converter, resets low.
// - Accumulate 1 to 64 samples per conversion.
// - Reference code selects internal or supply.
// - Converter clock divides by 2 to 256.
// - Capacitance bit passes to sampling circuit.
// - Startup delay before first sample.
// - Startup delay also after deep sleep wake.
// - Inter-sample delay holds sampling capacitor open.
// - Dither bit increments delay each sample.
// - Dithered delay wraps from 15 to 0.
// - Window mode chooses flag condition.
// - Window compares 16-bit result and thresholds.
// - Standby freezes sequencer unless run bit set; converter stays powered.
// - Start bit busy indicator; zero write aborts.
// - Flags clear by one write or result read.
// - Window compare once, after last sample.
// - Interrupt while flag and enable both set.
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        aclk,        // Peripheral clock, 20 MHz.
  input  wire logic        aresetn,     // Synchronous reset, low.
  input  wire logic [7:0]  awaddr,      // Write address.
  input  wire logic        awvalid,     // Write address valid.
  output logic             awready,     // Write address ready.
  input  wire logic [31:0] wdata,       // Write data.
  input  wire logic [3:0]  wstrb,       // Write byte strobes.
  input  wire logic        wvalid,      // Write data valid.
  output logic             wready,      // Write data ready.
  output logic [1:0]       bresp,       // Write response.
  output logic             bvalid,      // Write response valid.
  input  wire logic        bready,      // Write response ready.
  input  wire logic [7:0]  araddr,      // Read address.
  input  wire logic        arvalid,     // Read address valid.
  output logic             arready,     // Read address ready.
  output logic [31:0]      rdata,       // Read data.
  output logic [1:0]       rresp,       // Read response.
  output logic             rvalid,      // Read data valid.
  input  wire logic        rready,      // Read data ready.
  input  wire logic        standby,     // Chip is in standby sleep.
  input  wire logic        deep_wake,   // Pulse: woke to measure.
  input  wire logic        ana_ack,     // Analog conversion done.
  input  wire logic [9:0]  ana_value,   // Analog 10-bit value.
  output logic             ana_sample,  // Request one sample.
  output logic             ana_gap,     // Capacitor open in delay.
  output logic             adc_on,      // Converter powered.
  output logic             ref_vdd,     // Supply as reference.
  output logic             cap_reduced, // Reduced sample cap.
  output logic             irq_ready,   // Result ready request.
  output logic             irq_window   // Window match request.
);
  // Whole module state in one record.
  typedef struct packed {
    seq_state_t  st;        // Sequencer state.
    logic [7:0]  run;       // Run control.
    logic [7:0]  acc;       // Accumulation control.
    logic [7:0]  refclk;    // Reference and clock control.
    logic [7:0]  dly;       // Delay control.
    logic [7:0]  win;       // Window mode control.
    logic [7:0]  ien;       // Interrupt enables.
    logic        start_conversion;    // Conversion in progress.
    logic [1:0]  flags;     // Window match, result ready.
    logic [15:0] res;       // Conversion output.
    logic [15:0] wlt;       // Low threshold.
    logic [15:0] wht;       // High threshold.
    logic [15:0] sum;       // Running accumulation.
    logic [6:0]  nsamp;     // Samples taken this conversion.
    logic [8:0]  wcnt;      // Delay countdown in ticks.
    logic        need_init; // Startup delay pending.
    logic        en_seen;   // Enable as of last cycle.
    logic        int_seen;  // Internal reference last cycle.
    logic        ack_m;     // Acknowledge, first sync stage.
    logic        ack_s;     // Acknowledge, synchronised.
    logic [9:0]  val_m;     // Value, first sync stage.
    logic [9:0]  val_s;     // Value, synchronised.
    logic        aw_have;   // Write address held.
    logic        w_have;    // Write data held.
    logic [5:0]  waddr;     // Held write word index.
    logic [31:0] wdat;      // Held write data.
    logic [3:0]  wstb;      // Held write strobes.
    logic        awready;   // Bus handshake outputs follow.
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        req;       // Sample request.
    logic        gap;       // Capacitor open between samples.
    logic        ref_vdd;   // Decoded reference choice.
    logic        irq_rdy;   // Interrupt outputs.
    logic        irq_win;
  } seq_s_t;

  seq_s_t      q;
  seq_s_t      d;
  logic        tick;        // Converter clock enable.
  logic        run_en;      // Enable bit.
  logic        run_ok;      // Enabled and not stopped by standby.
  logic        do_wr;       // Register write happens this cycle.
  logic        start_wr;    // Software wrote start one.
  logic        abort_wr;    // Software wrote start zero.
  logic        dly_wr;      // Software wrote the delay register.
  logic        last;        // Final sample of the accumulation.
  logic        done;        // Conversion completes this cycle.
  logic        win_hit;     // Window condition on the sum.
  logic [1:0]  clr;         // Flag clear requests.
  logic [1:0]  set;         // Flag set events.
  logic [15:0] samp;        // Sample after resolution select.
  logic [6:0]  target;      // Samples per conversion.
  logic [3:0]  sdly;        // Inter-sample delay field.

  conv_clock_if clk_if ();

  conv_clock_divider u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div     (clk_if.gen)
  );

  assign clk_if.clock_divider = q.refclk[CLOCK_DIVIDER_LSB +: 3];
  assign clk_if.run   = run_en;
  assign tick         = clk_if.tick;
  assign run_en       = q.run[EN_BIT];
  // Standby halts the sequencer in place unless run-in-standby is set.
  assign run_ok = run_en & (~standby | q.run[STBY_BIT]);
  assign sdly   = q.dly[SDLY_LSB +: 4];

  // Window test on unsigned values; reserved modes never match.
  always_comb begin
    unique case (q.win[2:0])
      WIN_BELOW: win_hit = q.sum < q.wlt;
      WIN_ABOVE: win_hit = q.sum > q.wht;
      WIN_IN:    win_hit = (q.sum > q.wlt) && (q.sum < q.wht);
      WIN_OUT:   win_hit = (q.sum < q.wlt) || (q.sum > q.wht);
      default:   win_hit = 1'b0;
    endcase
  end

  // Next-state logic: synchronisers, bus slave, then sequencer.
  always_comb begin
    d = q;
    // Analog pins pass two flip-flops before use.
    d.ack_m = ana_ack;
    d.ack_s = q.ack_m;
    d.val_m = ana_value;
    d.val_s = q.val_m;
    // Eight-bit mode drops the two lowest bits.
    samp = q.run[RES8_BIT] ? {8'h00, q.val_s[9:2]}
                           : {6'h00, q.val_s};
    // Reserved accumulation code counts as 64.
    target = 7'(7'h01 << ((q.acc[2:0] > ACC_MAX) ? ACC_MAX
                                                 : q.acc[2:0]));
    last = (q.nsamp + 7'h01) == target;
    done = 1'b0;
    start_wr = 1'b0;
    abort_wr = 1'b0;
    dly_wr = 1'b0;
    clr = 2'b00;
    set = 2'b00;
    do_wr = q.aw_have & q.w_have & ~q.bvalid;

    // Write address and data are taken independently.
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awready = 1'b0;
      d.waddr   = awaddr[7:2];
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wready = 1'b0;
      d.wdat   = wdata;
      d.wstb   = wstrb;
    end
    if (do_wr) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
    end
    if (q.bvalid && bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // Reads answer one cycle after the address is taken.
    if (arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = RESP_OKAY;
      d.rdata   = 32'h0000_0000;
      case (araddr[7:2])
        IDX_RUN:    d.rdata[7:0] = q.run;
        IDX_ACC:    d.rdata[7:0] = q.acc;
        IDX_REFCLK: d.rdata[7:0] = q.refclk;
        IDX_DLY:    d.rdata[7:0] = q.dly;
        IDX_WIN:    d.rdata[7:0] = q.win;
        IDX_CMD:    d.rdata[0]   = q.start_conversion;
        IDX_IEN:    d.rdata[7:0] = q.ien;
        IDX_FLAG:   d.rdata[1:0] = q.flags;
        IDX_RES: begin
          d.rdata[15:0] = q.res;
          clr = 2'b11;
        end
        IDX_WLT:    d.rdata[15:0] = q.wlt;
        IDX_WHT:    d.rdata[15:0] = q.wht;
        default:    d.rresp = RESP_SLV;
      endcase
    end
    if (q.rvalid && rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end

    // Sequencer; it freezes in standby unless the run bit is set.
    if (run_ok) begin
      case (q.st)
        ST_IDLE: begin
          // Only a software start leaves idle.
          if (q.start_conversion && !q.ack_s) begin
            d.sum   = 16'h0000;
            d.nsamp = 7'h00;
            d.wcnt  = init_cycles(q.dly[INIT_LSB +: 3]);
            if (q.need_init && d.wcnt != 9'h000) begin
              d.st = ST_INIT;
            end else begin
              d.need_init = 1'b0;
              d.st        = ST_SAMPLE;
              d.req       = 1'b1;
            end
          end
        end
        ST_INIT: begin
          if (tick) begin
            d.wcnt = q.wcnt - 9'h001;
            if (q.wcnt == 9'h001) begin
              d.need_init = 1'b0;
              d.st        = ST_SAMPLE;
              d.req       = 1'b1;
            end
          end
        end
        ST_SAMPLE: begin
          if (q.ack_s) begin
            d.sum = q.sum + samp;
            d.req = 1'b0;
            d.st  = ST_RELEASE;
            if (q.dly[DITH_BIT]) begin
              // Four-bit add wraps 15 to 0.
              d.dly[SDLY_LSB +: 4] = sdly + 4'h1;
            end
          end
        end
        ST_RELEASE: begin
          if (!q.ack_s) begin
            d.nsamp = q.nsamp + 7'h01;
            if (last) begin
              done = 1'b1;
            end else if (sdly != 4'h0) begin
              d.wcnt = {5'h00, sdly};
              d.gap  = 1'b1;
              d.st   = ST_GAP;
            end else begin
              d.req = 1'b1;
              d.st  = ST_SAMPLE;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            d.wcnt = q.wcnt - 9'h001;
            if (q.wcnt == 9'h001) begin
              d.gap = 1'b0;
              d.req = 1'b1;
              d.st  = ST_SAMPLE;
            end
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end

    // Completion stores the sum and compares it once.
    if (done) begin
      d.res = q.sum;
      set[RDY_BIT] = 1'b1;
      set[WIN_BIT] = win_hit;
      if (q.run[FREE_BIT]) begin
        d.sum   = 16'h0000;
        d.nsamp = 7'h00;
        d.req   = 1'b1;
        d.st    = ST_SAMPLE;
      end else begin
        d.start_conversion = 1'b0;
        d.st     = ST_IDLE;
      end
    end

    // Register writes land after the sequencer's own updates.
    if (do_wr && q.wstb[0]) begin
      case (q.waddr)
        IDX_RUN:    d.run    = q.wdat[7:0] & RUN_WMASK;
        IDX_ACC:    d.acc    = q.wdat[7:0] & ACC_WMASK;
        IDX_REFCLK: d.refclk = q.wdat[7:0] & REF_WMASK;
        IDX_DLY: begin
          d.dly  = q.wdat[7:0] & DLY_WMASK;
          dly_wr = 1'b1;
        end
        IDX_WIN:    d.win    = q.wdat[7:0] & WIN_WMASK;
        IDX_IEN:    d.ien    = q.wdat[7:0] & IEN_WMASK;
        IDX_FLAG:   clr      = clr | q.wdat[1:0];
        IDX_CMD: begin
          start_wr = q.wdat[0];
          abort_wr = ~q.wdat[0];
        end
        IDX_WLT:    d.wlt[7:0] = q.wdat[7:0];
        IDX_WHT:    d.wht[7:0] = q.wdat[7:0];
        default:    d.bresp = (q.waddr == IDX_RES) ? RESP_OKAY
                                                   : RESP_SLV;
      endcase
    end
    if (do_wr && q.wstb[1]) begin
      if (q.waddr == IDX_WLT) begin
        d.wlt[15:8] = q.wdat[15:8];
      end
      if (q.waddr == IDX_WHT) begin
        d.wht[15:8] = q.wdat[15:8];
      end
    end
    if (start_wr && run_en) begin
      d.start_conversion = 1'b1;
    end

    // Disable or a zero write stops any conversion.
    if (!run_en || (abort_wr && q.start_conversion)) begin
      d.start_conversion = 1'b0;
      d.st     = ST_IDLE;
      d.req    = 1'b0;
      d.gap    = 1'b0;
    end

    // Startup delay is owed after enable, internal ref, or wake.
    d.en_seen  = run_en;
    d.int_seen = (q.refclk[REF_LSB +: 2] == 2'h0);
    if ((run_en && !q.en_seen) || (d.int_seen && !q.int_seen) ||
        deep_wake) begin
      d.need_init = 1'b1;
    end
    // Reserved reference codes keep the internal one.
    d.ref_vdd = (q.refclk[REF_LSB +: 2] == REF_VDD);

    // Hardware set wins over a clear in the same cycle.
    d.flags   = (q.flags & ~clr) | set;
    d.irq_rdy = d.flags[RDY_BIT] & d.ien[RDY_BIT];
    d.irq_win = d.flags[WIN_BIT] & d.ien[WIN_BIT];
  end

  // State register; reset leaves the bus ready and registers clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.run     <= REG_RESET;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready     = q.awready;
  assign wready      = q.wready;
  assign bresp       = q.bresp;
  assign bvalid      = q.bvalid;
  assign arready     = q.arready;
  assign rdata       = q.rdata;
  assign rresp       = q.rresp;
  assign rvalid      = q.rvalid;
  assign ana_sample  = q.req;
  assign ana_gap     = q.gap;
  assign adc_on      = q.run[EN_BIT];
  assign ref_vdd     = q.ref_vdd;
  assign cap_reduced = q.refclk[CAP_BIT];
  assign irq_ready   = q.irq_rdy;
  assign irq_window  = q.irq_win;

  sequence s_last_done;
    q.st == ST_RELEASE && !q.ack_s && last && run_ok;
  endsequence
  sequence s_abort;
    abort_wr && q.start_conversion && run_en;
  endsequence

  a_off_idle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !run_en |=> q.st == ST_IDLE && !q.start_conversion)
    else $error("converter busy while disabled");
  a_start_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.st == ST_IDLE && !q.start_conversion |=> q.st == ST_IDLE)
    else $error("conversion left idle without start");
  a_free_chain: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_last_done ##0 q.run[FREE_BIT] && !abort_wr && run_en
    |=> q.st == ST_SAMPLE && q.flags[RDY_BIT] && q.start_conversion)
    else $error("free running did not restart");
  a_acc_count: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_last_done |=> q.res == $past(q.sum) &&
    q.nsamp == ($past(q.run[FREE_BIT]) ? 7'h00 : $past(target)))
    else $error("result stored at wrong sample count");
  a_abort_stop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_abort |=> !q.start_conversion && q.st == ST_IDLE && !q.req)
    else $error("zero write did not abort");
  a_dly_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.st == ST_SAMPLE && q.ack_s && run_ok && q.dly[DITH_BIT] &&
    sdly == 4'hF && !dly_wr |=> sdly == 4'h0)
    else $error("dithered delay failed to wrap");
  a_res8_first: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.st == ST_SAMPLE && q.ack_s && run_ok && q.nsamp == 7'h00 &&
    q.run[RES8_BIT] && run_en |=> q.sum <= 16'h00FF)
    else $error("eight-bit sample kept low bits");
  a_irq_level: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.irq_rdy == (q.flags[RDY_BIT] && q.ien[RDY_BIT]))
    else $error("ready request disagrees with flag");
  a_init_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.st == ST_INIT && q.wcnt > 9'h001 && run_en && !abort_wr
    |=> q.st == ST_INIT)
    else $error("startup delay cut short");
  a_win_none: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.win[2:0] == WIN_NONE || q.win[2:0] > WIN_OUT |-> !win_hit)
    else $error("window matched in disabled mode");
endmodule

// ### src/adc_seq_pkg.sv
// Constants and types shared by the conversion sequencer files.
package adc_seq_pkg;
  // Register word indices; the byte address is four times the index.
  localparam logic [5:0] IDX_RUN    = 6'h00;
  localparam logic [5:0] IDX_ACC    = 6'h01;
  localparam logic [5:0] IDX_REFCLK = 6'h02;
  localparam logic [5:0] IDX_DLY    = 6'h03;
  localparam logic [5:0] IDX_WIN    = 6'h04;
  localparam logic [5:0] IDX_CMD    = 6'h08;
  localparam logic [5:0] IDX_IEN    = 6'h0A;
  localparam logic [5:0] IDX_FLAG   = 6'h0B;
  localparam logic [5:0] IDX_RES    = 6'h10;
  localparam logic [5:0] IDX_WLT    = 6'h12;
  localparam logic [5:0] IDX_WHT    = 6'h14;
  // Writable bits of each byte register; the rest read as zero.
  localparam logic [7:0] RUN_WMASK  = 8'h87;
  localparam logic [7:0] ACC_WMASK  = 8'h07;
  localparam logic [7:0] REF_WMASK  = 8'h77;
  localparam logic [7:0] DLY_WMASK  = 8'hFF;
  localparam logic [7:0] WIN_WMASK  = 8'h07;
  localparam logic [7:0] IEN_WMASK  = 8'h03;
  localparam logic [7:0] REG_RESET  = 8'h00;
  // Field positions.
  localparam int EN_BIT    = 0;
  localparam int FREE_BIT  = 1;
  localparam int RES8_BIT  = 2;
  localparam int STBY_BIT  = 7;
  localparam int CAP_BIT   = 6;
  localparam int REF_LSB   = 4;
  localparam int CLOCK_DIVIDER_LSB = 0;
  localparam int DITH_BIT  = 4;
  localparam int SDLY_LSB  = 0;
  localparam int INIT_LSB  = 5;
  localparam int RDY_BIT   = 0;
  localparam int WIN_BIT   = 1;
  // Codes.
  localparam logic [1:0] REF_VDD   = 2'h1;
  localparam logic [2:0] ACC_MAX   = 3'h6;
  localparam logic [2:0] WIN_NONE  = 3'h0;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_IN    = 3'h3;
  localparam logic [2:0] WIN_OUT   = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;
  // Sequencer states, Gray coded along idle-init-sample-release-gap.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_INIT = 3'h1, ST_SAMPLE = 3'h3,
    ST_RELEASE = 3'h2, ST_GAP = 3'h6
  } seq_state_t;
  // Startup delay in converter clock cycles; reserved codes act as 256.
  function automatic logic [8:0] init_cycles(input logic [2:0] code);
    logic [8:0] c;
    c = 9'h000;
    if (code != 3'h0) begin
      c = (code > 3'h5) ? 9'h100 : 9'(9'h008 << code);
    end
    return c;
  endfunction
endpackage

// ### src/conv_clock_divider.sv
// Converter clock enable generator dividing the peripheral clock.
`timescale 1ns/10ps
module conv_clock_divider
  import adc_seq_pkg::*;
(
  input wire logic aclk,    // Peripheral clock.
  input wire logic aresetn, // Synchronous reset, active low.
  conv_clock_if.gen div     // Division code in, tick out.
);
  typedef struct packed {
    logic [7:0] cnt;  // Free count of peripheral clocks.
    logic       tick; // Registered enable pulse.
  } div_state_t;
  div_state_t q;
  div_state_t d;
  logic [7:0] mask;   // Low bits that must all be set for a tick.

  // A tick comes every two to the power code plus one cycles.
  always_comb begin
    d = q;
    // Widen the code first so that code 7 does not wrap to a shift of 0.
    mask = 8'(({1'b0, 8'h01} << (4'(div.clock_divider) + 4'h1)) - 9'h001);
    if (div.run) begin
      d.cnt  = q.cnt + 8'h01;
      d.tick = ((q.cnt & mask) == mask);
    end else begin
      d.cnt  = 8'h00;
      d.tick = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign div.tick = q.tick;

  // Two ticks are never adjacent, even at the fastest code.
  a_tick_spacing: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.tick |=> !q.tick)
    else $error("converter tick repeated on adjacent cycles");
endmodule

// ### src/conv_clock_if.sv
// Carrier between the sequencer and its converter clock divider.
`timescale 1ns/10ps
interface conv_clock_if;
  logic [2:0] clock_divider;  // Division code.
  logic       run;    // Divider counts while high.
  logic       tick;   // One-cycle converter clock enable.
  modport ctrl (output clock_divider, output run, input tick);
  modport gen  (input clock_divider, input run, output tick);
endinterface

// ### verification/ana_front_model.sv
// Behavioural analog front end answering the sample handshake.
`timescale 1ns/10ps
module ana_front_model (
  input  wire logic       aclk,  // Peripheral clock.
  input  wire logic       slow,  // Stretch each answer.
  input  wire logic [9:0] val,   // Level being converted.
  input  wire logic       samp,  // Sample request from the device.
  output logic            ack,   // Conversion done.
  output logic [9:0]      value  // Converted value.
);
  int cnt = 0; // Cycles since the request rose.
  initial ack = 1'b0;
  // Ack rises after a delay and falls once the request is dropped.
  always @(posedge aclk) begin
    if (!samp) begin
      ack <= 1'b0;
      cnt <= 0;
    end else if (cnt < (slow ? 9 : 2)) cnt <= cnt + 1;
    else ack <= 1'b1;
  end
  // Outside a handshake the value is junk, so show the inverse.
  assign value = (samp || ack) ? val : ~val;
endmodule

// ### verification/tb.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/10ps
module tb;
  import adc_seq_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, standby = 0, deep_wake = 0, slow = 0;
  logic [7:0] awaddr = 0, araddr = 0, lf = 8'h5F;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, r;
  logic [9:0] v = 0, ana_value;
  logic awready, wready, bvalid, arready, rvalid, ana_ack, ana_sample;
  logic ana_gap, adc_on, ref_vdd, cap_reduced, irq_ready, irq_window, m, g;
  int fails = 0, num_checks = 0, i, k, e;
  logic [7:0] mk [5] = '{RUN_WMASK, ACC_WMASK, REF_WMASK, DLY_WMASK,
                         WIN_WMASK};
  adc_conversion_sequencer adc_conversion_sequencer_i (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .standby, .deep_wake, .ana_ack, .ana_value, .ana_sample,
    .ana_gap, .adc_on, .ref_vdd, .cap_reduced, .irq_ready, .irq_window);
  ana_front_model ana_front_model_i (.aclk, .slow, .val(v),
    .samp(ana_sample), .ack(ana_ack), .value(ana_value));
  // Clock of 50 ns period.
  initial forever #25 aclk = ~aclk;
  // Eight-bit feedback shift register for stimulus values.
  function automatic logic [7:0] nx(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Reference window decision with thresholds 1024 and 3072.
  function automatic logic win(int md, int x);
    case (md)
      1: return x < 1024;
      2: return x > 3072;
      3: return x > 1024 && x < 3072;
      4: return x < 1024 || x > 3072;
      default: return 1'b0;
    endcase
  endfunction
  task automatic close_out;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask
  // A used-up wait counts as a mismatch and ends the run.
  task automatic to(int n);
    if (n >= 3000) begin
      fails++;
      close_out();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] dd);
    int j;
    logic pa, pw;
    pa = 1;
    pw = 1;
    awaddr <= a;
    wdata <= dd;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    for (j = 0; j < 3000 && (pa || pw); j++) begin
      @(posedge aclk);
      if (awready) begin pa = 0; awvalid <= 0; end
      if (wready) begin pw = 0; wvalid <= 0; end
    end
    to(j);
    bready <= 1;
    for (j = 0; j < 3000; j++) begin
      @(posedge aclk);
      if (bvalid) break;
    end
    bready <= 0;
    r = bresp;
    to(j);
  endtask
  task automatic rdr(logic [7:0] a);
    int j;
    araddr <= a;
    arvalid <= 1;
    for (j = 0; j < 3000; j++) begin
      @(posedge aclk);
      if (arready) break;
    end
    to(j);
    arvalid <= 0;
    rready <= 1;
    for (j = 0; j < 3000; j++) begin
      @(posedge aclk);
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
    to(j);
  endtask
  // Main sequence: reset, register map, then five conversions.
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (i = 0; i < 5; i++) begin
      rdr(8'(4 * i));
      chk("reset", d, 0);
      wr(8'(4 * i), 32'h0000_00FF);
      rdr(8'(4 * i));
      chk("mask", d, {24'h0, mk[i]});
      wr(8'(4 * i), 0);
    end
    // Supply reference, reduced cap, converter clock divided by four.
    wr(8'h08, 32'h0000_0051);
    @(posedge aclk);
    chk("ref", ref_vdd, 1);
    chk("cap", cap_reduced, 1);
    rdr(8'h3C);
    chk("unmapped", d, 0);
    chk("rresp", r, RESP_SLV);
    wr(8'h3C, 1);
    chk("bresp", r, RESP_SLV);
    wr(8'h48, 32'h0000_0400);
    wr(8'h50, 32'h0000_0C00);
    wr(8'h28, 3);
    for (k = 0; k < 5; k++) begin
      lf = nx(lf);
      v <= {lf, lf[1:0]};
      slow <= !k[0];
      wr(0, {29'h0, k[0], k == 4, 1'b1});
      chk("on", adc_on, 1);
      wr(8'h04, k % 4);
      // Run three owes a startup delay of 16 and dithers from 15.
      wr(8'h0C, (k == 3) ? 32'h0000_003F : k);
      deep_wake <= k == 3;
      @(posedge aclk);
      deep_wake <= 0;
      wr(8'h10, k);
      wr(8'h20, 1);
      rdr(8'h20);
      chk("busy", d, 1);
      chk("init", ana_sample, k != 3);
      if (k == 2) begin
        // Standby without the run bit must hold the conversion still.
        standby <= 1;
        repeat (150) @(posedge aclk);
        chk("stby", irq_ready, 0);
        standby <= 0;
      end
      g = 0;
      for (i = 0; i < 3000 && !irq_ready; i++) begin
        @(posedge aclk);
        g |= ana_gap;
      end
      to(i);
      chk("gap", g, k % 4 != 0);
      e = (1 << (k % 4)) * (k[0] ? v >> 2 : v);
      m = win(k, e);
      chk("irq_win", irq_window, m);
      rdr(8'h2C);
      chk("flags", d, {m, 1'b1});
      if (k == 3) begin
        // Eight samples step the delay from 15 through the wrap to 7.
        rdr(8'h0C);
        chk("dither", d, 32'h0000_0037);
      end
      if (k == 4) begin
        rdr(8'h20);
        chk("free", d, 1);
        wr(8'h20, 0);
        @(posedge aclk);
        chk("abort", ana_sample, 0);
        rdr(8'h20);
        chk("idle", d, 0);
      end
      if (k == 1) begin
        wr(8'h2C, 0);
        rdr(8'h2C);
        chk("wr0", d, {m, 1'b1});
        wr(8'h2C, 3);
        rdr(8'h2C);
        chk("wr1", d, 0);
      end
      rdr(8'h40);
      chk("result", d, e);
      rdr(8'h2C);
      chk("rdclr", d, 0);
      $display("test %0d done", k);
    end
    close_out();
  end
endmodule
